//--- hw/master_init_trap.sv
// Master initialization: holds the trap force after reset or a restart.
// Assumes restart is a one-cycle pulse from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module master_init_trap #(
  parameter int HOLD = 2
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic restart,
  output logic      trap_force
);

  localparam int CW = $clog2(HOLD + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          force_on;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (restart)
    begin
      state_next.count = CW'(HOLD - 1);
      state_next.force_on = 1'b1;
    end
    else if (state_reg.count != '0)
      state_next.count = state_reg.count - CW'(1);
    else
      state_next.force_on = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '{count: CW'(HOLD - 1), force_on: 1'b1};
    else if (clk_en)
      state_reg <= state_next;
  end

  assign trap_force = state_reg.force_on;

endmodule : master_init_trap
`default_nettype wire

//--- hw/microcode_operand_field_decoder.sv
// Operand field decoder for the 20-bit microinstruction, with APB registers.
// Assumes instr_word/instr_valid come from the ROM on pclk; input_strobe_n is a pin.
`timescale 1ns/1ps
`default_nettype none
`include "operand_decode_params.svh"
module microcode_operand_field_decoder #(
  parameter logic [11:0] TRAP_ADDR  = `TRAP_ADDR_DEFAULT,
  parameter int          STROBE_CYC = `STROBE_CYC,
  parameter int          TRAP_HOLD  = `TRAP_HOLD_CYC
)(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire logic [`INSTR_W-1:0]           instr_word,
  input  wire logic                          instr_valid,
  input  wire logic [7:0]                    io_data,
  input  wire logic                          input_strobe_n,
  output operand_decode_pkg::a_src_e         a_src,
  output logic [2:0]                         a_file_sel,
  output logic [3:0]                         a_imm,
  output operand_decode_pkg::bc_sel_e        b_sel,
  output logic [2:0]                         b_file_sel,
  output operand_decode_pkg::bc_sel_e        c_sel,
  output logic [2:0]                         c_file_sel,
  output logic [3:0]                         aux_sel,
  output logic                               aux_valid,
  output operand_decode_pkg::mem_op_e        mem_op,
  output logic                               pc_inc,
  output logic                               pc_dec,
  output logic                               control_strobe_n,
  output logic                               output_strobe_n,
  output logic                               address_strobe_n,
  output logic [7:0]                         addr_latch,
  output logic                               addr_latch_load,
  output logic                               trap_force,
  output logic [11:0]                        trap_addr
);

  typedef struct packed {
    operand_decode_pkg::a_src_e   a_src;
    logic [2:0]                   a_file;
    logic [3:0]                   a_imm;
    operand_decode_pkg::bc_sel_e  b_sel;
    logic [2:0]                   b_file;
    operand_decode_pkg::bc_sel_e  c_sel;
    logic [2:0]                   c_file;
    logic [3:0]                   aux_sel;
    logic                         aux_valid;
    operand_decode_pkg::mem_op_e  mem_op;
    operand_decode_pkg::pc_step_e pc_pend;
    logic                         pc_inc;
    logic                         pc_dec;
    logic [2:0]                   fire;
    logic [7:0]                   addr_latch;
    logic                         addr_latch_load;
    logic [11:0]                  trap_addr;
    logic                         decode_en;
    logic                         trap_restart;
    logic [3:0]                   sticky;
    logic [`INSTR_W-1:0]          last_instr;
    logic                         sync1;
    logic                         sync2;
    logic                         sync3;
    logic                         pready;
    logic [31:0]                  prdata;
    logic                         pslverr;
  } state_s;

  state_s     state_reg;
  state_s     state_next;
  logic [2:0] strobe_n_w;
  logic [2:0] busy_w;
  logic       trap_w;

  function automatic operand_decode_pkg::a_dec_s a_decode(input logic [3:0] code, input logic restricted);
    a_decode = '{src: operand_decode_pkg::A_FILE, step: operand_decode_pkg::PC_HOLD, illegal: 1'b0};
    case (code)
      `A_MEM_HIGH:  a_decode.src = operand_decode_pkg::A_MEM_HIGH;
      `A_HIGH_DEC:  a_decode = '{operand_decode_pkg::A_MEM_HIGH, operand_decode_pkg::PC_DEC, 1'b0};
      `A_HIGH_INC:  a_decode = '{operand_decode_pkg::A_MEM_HIGH, operand_decode_pkg::PC_INC, 1'b0};
      `A_DUMMY_DEC: a_decode = '{operand_decode_pkg::A_DUMMY, operand_decode_pkg::PC_DEC, 1'b0};
      `A_MEM_LOW:   a_decode.src = operand_decode_pkg::A_MEM_LOW;
      `A_LOW_DEC:   a_decode = '{operand_decode_pkg::A_MEM_LOW, operand_decode_pkg::PC_DEC, 1'b0};
      `A_LOW_INC:   a_decode = '{operand_decode_pkg::A_MEM_LOW, operand_decode_pkg::PC_INC, 1'b0};
      `A_DUMMY_INC: a_decode = '{operand_decode_pkg::A_DUMMY, operand_decode_pkg::PC_INC, 1'b0};
      default:      ;
    endcase
    // Undefined codes here select nothing and never step the counter
    if (restricted && code[3] && code != `A_MEM_HIGH && code != `A_MEM_LOW)
      a_decode = '{operand_decode_pkg::A_NONE, operand_decode_pkg::PC_HOLD, 1'b1};
  endfunction : a_decode

  function automatic operand_decode_pkg::bc_sel_e bc_decode(input logic [3:0] code, input logic xbit);
    case (code)
      `BC_CODE_8: bc_decode = xbit ? operand_decode_pkg::BC_STATUS_3 : operand_decode_pkg::BC_IO_HIGH;
      `BC_CODE_9: bc_decode = xbit ? operand_decode_pkg::BC_STATUS_4 : operand_decode_pkg::BC_IO_LOW;
      `BC_CODE_A: bc_decode = xbit ? operand_decode_pkg::BC_PC_2 : operand_decode_pkg::BC_STATUS_1;
      `BC_CODE_B: bc_decode = xbit ? operand_decode_pkg::BC_PC_3 : operand_decode_pkg::BC_STATUS_2;
      `BC_CODE_C: bc_decode = xbit ? operand_decode_pkg::BC_PC_4 : operand_decode_pkg::BC_PC_1;
      `BC_CODE_D: bc_decode = operand_decode_pkg::BC_MEM_HIGH;
      `BC_CODE_E: bc_decode = operand_decode_pkg::BC_MEM_LOW;
      `BC_CODE_F: bc_decode = operand_decode_pkg::BC_DUMMY;
      default:    bc_decode = operand_decode_pkg::BC_FILE;
    endcase
  endfunction : bc_decode

  always_comb
  begin
    logic [4:0]                 op;
    logic [4:0]                 code2;
    logic                       mini;
    logic                       control_io_op;
    logic                       restricted;
    logic                       reg_form;
    logic                       a_used;
    logic                       take;
    logic [3:0]                 set_bits;
    logic [3:0]                 clr_bits;
    logic                       wr_take;
    logic                       mapped;
    logic [31:0]                rd_val;
    operand_decode_pkg::a_dec_s ad;

    state_next = state_reg;
    op = instr_word[19:15];
    code2 = instr_word[14:10];
    mini = (op == `OP_MINI);
    control_io_op = mini && (code2 == `CODE2_CIO);
    restricted = mini && !control_io_op && code2 != `CODE2_SR && code2 != `CODE2_TPI;
    reg_form = !op[4] && !mini;
    // Unconditional and mask branches carry no A field
    a_used = !control_io_op && !(op[4] && op[3]) && !(op[4:2] == 3'b101);
    take = instr_valid && state_reg.decode_en && !trap_w;
    set_bits = 4'h0;
    rd_val = 32'h0000_0000;
    ad = a_decode(instr_word[7:4], restricted);

    state_next.pc_inc = (state_reg.pc_pend == operand_decode_pkg::PC_INC);
    state_next.pc_dec = (state_reg.pc_pend == operand_decode_pkg::PC_DEC);
    state_next.pc_pend = operand_decode_pkg::PC_HOLD;
    state_next.fire = 3'h0;
    state_next.addr_latch_load = 1'b0;
    state_next.trap_restart = 1'b0;
    state_next.trap_addr = TRAP_ADDR;

    if (take)
    begin
      state_next.last_instr = instr_word;
      state_next.a_src = operand_decode_pkg::A_NONE;
      state_next.b_sel = operand_decode_pkg::BC_NONE;
      state_next.c_sel = operand_decode_pkg::BC_NONE;
      state_next.aux_valid = 1'b0;
      state_next.mem_op = operand_decode_pkg::MEM_IDLE;
      if (reg_form && op[3])
      begin
        state_next.a_src = operand_decode_pkg::A_IMM;
        state_next.a_imm = instr_word[7:4];
      end
      else if (a_used)
      begin
        state_next.a_src = ad.src;
        state_next.a_file = instr_word[6:4];
        state_next.pc_pend = ad.step;
        set_bits[`ST_ILLEGAL_A] = ad.illegal;
      end
      if (reg_form)
      begin
        state_next.b_sel = bc_decode(instr_word[13:10], instr_word[`INSTR_W-6]);
        state_next.b_file = instr_word[12:10];
        state_next.c_file = instr_word[2:0];
        if (instr_word[3:0] == `BC_CODE_D || instr_word[3:0] == `BC_CODE_E)
          set_bits[`ST_ILLEGAL_C] = 1'b1;
        else if (instr_word[3:0] != `BC_CODE_F)
          state_next.c_sel = bc_decode(instr_word[3:0], instr_word[`INSTR_W-6]);
      end
      if (restricted)
      begin
        state_next.aux_sel = instr_word[3:0];
        state_next.aux_valid = 1'b1;
      end
      if (reg_form || mini)
      begin
        case (instr_word[9:8])
          `MEM_CODE_READ:   state_next.mem_op = operand_decode_pkg::MEM_READ8;
          `MEM_CODE_WRITE1: state_next.mem_op = operand_decode_pkg::MEM_WRITE1;
          `MEM_CODE_WRITE2: state_next.mem_op = operand_decode_pkg::MEM_WRITE2;
          default:          state_next.mem_op = operand_decode_pkg::MEM_IDLE;
        endcase
      end
      if (control_io_op && !instr_word[7])
      begin
        case (instr_word[6:0])
          `D_NOP:  ;
          `D_CTRL: state_next.fire[`STB_CTRL] = 1'b1;
          `D_OUT:  state_next.fire[`STB_OUT] = 1'b1;
          `D_ADDR: state_next.fire[`STB_ADDR] = 1'b1;
          default: set_bits[`ST_ILLEGAL_IO] = 1'b1;
        endcase
      end
      else if (control_io_op)
      begin
        if (instr_word[6:0] == `D_NOP)
        begin
          state_next.addr_latch = io_data;
          state_next.addr_latch_load = 1'b1;
        end
        else
          set_bits[`ST_ILLEGAL_IO] = 1'b1;
      end
    end

    // Pin through three flops; falling edge caught sticky
    state_next.sync1 = input_strobe_n;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    set_bits[`ST_IN_STROBE] = state_reg.sync3 && !state_reg.sync2;

    wr_take = psel && penable && state_reg.pready && pwrite;
    clr_bits = 4'h0;
    if (wr_take && paddr == `REG_STATUS)
      clr_bits = pwdata[3:0];
    if (wr_take && paddr == `REG_CTRL)
    begin
      state_next.decode_en = pwdata[`CTRL_DECODE_EN];
      state_next.trap_restart = pwdata[`CTRL_TRAP];
    end
    // Hardware set wins over a same-cycle write-one clear
    state_next.sticky = (state_reg.sticky & ~clr_bits) | set_bits;

    mapped = 1'b1;
    case (paddr)
      `REG_CTRL:   rd_val = {30'h0, trap_w, state_reg.decode_en};
      `REG_STATUS: rd_val = {26'h0, trap_w, |busy_w, state_reg.sticky};
      `REG_LAST:   rd_val = {12'h0, state_reg.last_instr};
      `REG_LATCH:  rd_val = {24'h0, state_reg.addr_latch};
      default:     mapped = 1'b0;
    endcase
    state_next.pready = psel && penable && !state_reg.pready;
    state_next.prdata = (psel && penable && !state_reg.pready && !pwrite) ? rd_val : 32'h0000_0000;
    state_next.pslverr = psel && penable && !state_reg.pready && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.decode_en <= `CTRL_RESET;
      state_reg.trap_addr <= TRAP_ADDR;
      state_reg.sync1 <= 1'b1;
      state_reg.sync2 <= 1'b1;
      state_reg.sync3 <= 1'b1;
    end
    else if (clk_en)
      state_reg <= state_next;
  end

  // Address strobe reuses the 5 us width; a fire while busy is dropped
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_strobe
      strobe_pulse #(
        .CYCLES (STROBE_CYC)
      ) u_strobe (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .fire     (state_reg.fire[gi]),
        .strobe_n (strobe_n_w[gi]),
        .busy     (busy_w[gi])
      );
    end
  endgenerate

  master_init_trap #(
    .HOLD (TRAP_HOLD)
  ) u_trap (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .restart    (state_reg.trap_restart),
    .trap_force (trap_w)
  );

  assign pready           = state_reg.pready;
  assign prdata           = state_reg.prdata;
  assign pslverr          = state_reg.pslverr;
  assign a_src            = state_reg.a_src;
  assign a_file_sel       = state_reg.a_file;
  assign a_imm            = state_reg.a_imm;
  assign b_sel            = state_reg.b_sel;
  assign b_file_sel       = state_reg.b_file;
  assign c_sel            = state_reg.c_sel;
  assign c_file_sel       = state_reg.c_file;
  assign aux_sel          = state_reg.aux_sel;
  assign aux_valid        = state_reg.aux_valid;
  assign mem_op           = state_reg.mem_op;
  assign pc_inc           = state_reg.pc_inc;
  assign pc_dec           = state_reg.pc_dec;
  assign control_strobe_n = strobe_n_w[`STB_CTRL];
  assign output_strobe_n  = strobe_n_w[`STB_OUT];
  assign address_strobe_n = strobe_n_w[`STB_ADDR];
  assign addr_latch       = state_reg.addr_latch;
  assign addr_latch_load  = state_reg.addr_latch_load;
  assign trap_force       = trap_w;
  assign trap_addr        = state_reg.trap_addr;

endmodule : microcode_operand_field_decoder
`default_nettype wire

//--- hw/operand_decode_params.svh
// Offsets, field positions, codes and timing counts for the operand decoder.
// Assumes inclusion by its bare name; definitions only.
`ifndef OPERAND_DECODE_PARAMS_SVH
`define OPERAND_DECODE_PARAMS_SVH

`define CLK_MHZ          125
`define STROBE_NS        5000
`define STROBE_CYC       ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define TRAP_HOLD_CYC    2
// Arbitrary neutral default
`define TRAP_ADDR_DEFAULT 12'h000

`define INSTR_W          20
`define OP_MINI          5'h0B
`define CODE2_CIO        5'h00
`define CODE2_SR         5'h01
`define CODE2_TPI        5'h05

`define A_MEM_HIGH       4'h8
`define A_HIGH_DEC       4'h9
`define A_HIGH_INC       4'hA
`define A_DUMMY_DEC      4'hB
`define A_MEM_LOW        4'hC
`define A_LOW_DEC        4'hD
`define A_LOW_INC        4'hE
`define A_DUMMY_INC      4'hF

`define BC_CODE_8        4'h8
`define BC_CODE_9        4'h9
`define BC_CODE_A        4'hA
`define BC_CODE_B        4'hB
`define BC_CODE_C        4'hC
`define BC_CODE_D        4'hD
`define BC_CODE_E        4'hE
`define BC_CODE_F        4'hF

`define MEM_CODE_IDLE    2'h0
`define MEM_CODE_READ    2'h1
`define MEM_CODE_WRITE1  2'h2
`define MEM_CODE_WRITE2  2'h3

`define D_NOP            7'h00
`define D_CTRL           7'h10
`define D_OUT            7'h20
`define D_ADDR           7'h40

`define STB_CTRL         0
`define STB_OUT          1
`define STB_ADDR         2

`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_LAST         8'h08
`define REG_LATCH        8'h0C

`define CTRL_DECODE_EN   0
`define CTRL_TRAP        1
`define CTRL_RESET       1'b1
`define ST_ILLEGAL_A     0
`define ST_ILLEGAL_C     1
`define ST_ILLEGAL_IO    2
`define ST_IN_STROBE     3
`define ST_BUSY          4
`define ST_TRAP          5

`endif

//--- hw/operand_decode_pkg.sv
// Types shared by the operand decoder and its bench.
// Assumes nothing of its surroundings.
package operand_decode_pkg;

  typedef enum logic [2:0] {A_NONE, A_FILE, A_MEM_HIGH, A_MEM_LOW, A_DUMMY, A_IMM} a_src_e;

  typedef enum logic [3:0] {
    BC_NONE, BC_FILE, BC_IO_HIGH, BC_IO_LOW, BC_STATUS_1, BC_STATUS_2, BC_STATUS_3, BC_STATUS_4,
    BC_PC_1, BC_PC_2, BC_PC_3, BC_PC_4, BC_MEM_HIGH, BC_MEM_LOW, BC_DUMMY
  } bc_sel_e;

  typedef enum logic [1:0] {MEM_IDLE, MEM_READ8, MEM_WRITE1, MEM_WRITE2} mem_op_e;

  typedef enum logic [1:0] {PC_HOLD, PC_INC, PC_DEC} pc_step_e;

  typedef struct packed {
    a_src_e   src;
    pc_step_e step;
    logic     illegal;
  } a_dec_s;

endpackage : operand_decode_pkg

//--- hw/strobe_pulse.sv
// Fixed-width active-low pulse generator for one I/O strobe.
// Assumes fire is a one-cycle pulse from logic on pclk.
`timescale 1ns/1ps
`default_nettype none
module strobe_pulse #(
  parameter int CYCLES = 625
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic fire,
  output logic      strobe_n,
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          strobe_n;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (state_reg.count != '0)
    begin
      state_next.count = state_reg.count - CW'(1);
      state_next.strobe_n = (state_reg.count == CW'(1));
    end
    // A fire during a running pulse is dropped rather than stretching it
    else if (fire)
    begin
      state_next.count = CW'(CYCLES);
      state_next.strobe_n = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '{count: '0, strobe_n: 1'b1};
    else if (clk_en)
      state_reg <= state_next;
  end

  assign strobe_n = state_reg.strobe_n;
  assign busy     = (state_reg.count != '0);

endmodule : strobe_pulse
`default_nettype wire

//--- tb/io_peripheral_model.sv
// Peripheral on the strobe bus: answers a control strobe with an input strobe.
// Assumes strobes and the address latch change on pclk.
`timescale 1ns/1ps
`default_nettype none
module io_peripheral_model #(
  parameter logic [7:0] MY_ADDR = 8'h5A
)(
  input  wire logic       pclk,
  input  wire logic       address_strobe_n,
  input  wire logic [7:0] addr_latch,
  input  wire logic       control_strobe_n,
  output logic            input_strobe_n
);
  logic       enabled = 1'b0;
  logic       abs_d   = 1'b1;
  logic       cbs_d   = 1'b1;
  logic [2:0] cnt     = 3'h0;
  always @(posedge pclk)
  begin
    abs_d <= address_strobe_n;
    cbs_d <= control_strobe_n;
    if (abs_d && !address_strobe_n)
      enabled <= addr_latch == MY_ADDR;
    if (enabled && cbs_d && !control_strobe_n)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  // Pulled up; low three cycles to outlast the sync
  assign input_strobe_n = !(cnt inside {3'h1, 3'h2, 3'h3});
endmodule : io_peripheral_model
`default_nettype wire

//--- tb/microcode_operand_field_decoder_tb.sv
// Self-checking bench for the operand field decoder.
// Assumes package and design compiled first; clk_en stays high.
`timescale 1ns/1ps
`default_nettype none
module microcode_operand_field_decoder_tb;
  localparam int          STROBE_CYC = 4;
  localparam int          TRAP_HOLD  = 2;
  localparam logic [11:0] TRAP_ADDR  = 12'h3C5;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic        instr_valid, input_strobe_n, aux_valid, pc_inc, pc_dec, addr_latch_load, trap_force;
  logic        control_strobe_n, output_strobe_n, address_strobe_n;
  logic [7:0]  paddr, io_data, addr_latch;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] instr_word;
  logic [2:0]  a_file_sel, b_file_sel, c_file_sel;
  logic [3:0]  a_imm, aux_sel;
  logic [11:0] trap_addr;
  operand_decode_pkg::a_src_e  a_src;
  operand_decode_pkg::bc_sel_e b_sel, c_sel;
  operand_decode_pkg::mem_op_e mem_op;
  // Codes of bc_sel_e for B 8-F, X clear then set
  logic [3:0]  bmap [2][8] = '{'{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hC, 4'hD, 4'hE},
    '{4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE}};
  int          n_errors = 0;
  int          checked  = 0;
  int          cycles   = 0;

  microcode_operand_field_decoder #(.TRAP_ADDR(TRAP_ADDR), .STROBE_CYC(STROBE_CYC), .TRAP_HOLD(TRAP_HOLD))
  microcode_operand_field_decoder_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .instr_word, .instr_valid, .io_data, .input_strobe_n, .a_src,
    .a_file_sel, .a_imm, .b_sel, .b_file_sel, .c_sel, .c_file_sel, .aux_sel, .aux_valid, .mem_op, .pc_inc,
    .pc_dec, .control_strobe_n, .output_strobe_n, .address_strobe_n, .addr_latch, .addr_latch_load,
    .trap_force, .trap_addr);
  io_peripheral_model io_peripheral_model_inst (.pclk, .address_strobe_n, .addr_latch,
    .control_strobe_n, .input_strobe_n);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Returns just after the take edge
  task automatic exec(input logic [19:0] w);
    @(posedge pclk);
    instr_word  <= w;
    instr_valid <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
  endtask : exec
  task automatic final_report;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      final_report();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, instr_valid, paddr, pwdata, instr_word} = '0;
    clk_en  = 1'b1;
    io_data = 8'h5A;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(trap_force, 1'b1);
    chk(trap_addr, TRAP_ADDR);
    repeat (4) @(posedge pclk);
    chk(trap_force, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      exec({5'h00, 1'b0, 4'hF, i[1:0], i[3:0], 4'hF});
      chk(a_src, i < 8 ? operand_decode_pkg::A_FILE : i % 4 == 3 ? operand_decode_pkg::A_DUMMY :
        i < 12 ? operand_decode_pkg::A_MEM_HIGH : operand_decode_pkg::A_MEM_LOW);
      if (i < 8)
        chk(a_file_sel, i[2:0]);
      chk(mem_op, i[1:0]);
      chk(c_sel, operand_decode_pkg::BC_NONE);
      @(posedge pclk);
      #1;
      chk(pc_dec, i > 8 && (i % 4 == 1 || i == 11));
      chk(pc_inc, i > 8 && (i % 4 == 2 || i == 15));
    end
    for (int x = 0; x < 2; x++)
      for (int j = 0; j < 8; j++)
      begin
        exec({5'h00, x[0], j[3:0] + 4'h8, 2'h0, 4'h0, j[3:0] + 4'h8});
        chk(b_sel, bmap[x][j]);
        chk(c_sel, j > 4 ? operand_decode_pkg::BC_NONE : bmap[x][j]);
      end
    exec(20'h0664B);
    chk(c_sel, operand_decode_pkg::BC_PC_3);
    chk(a_file_sel, 3'h4);
    exec({5'h08, 1'b0, 4'h3, 2'h0, 4'hA, 4'h5});
    chk(a_imm, 4'hA);
    chk({b_file_sel, c_file_sel}, 6'h1D);
    @(posedge pclk);
    #1;
    chk(pc_inc, 1'b0);
    exec({5'h0B, 5'h02, 2'h0, 4'h9, 4'h7});
    chk(a_src, operand_decode_pkg::A_NONE);
    chk({aux_valid, aux_sel}, 5'h17);
    @(posedge pclk);
    #1;
    chk(pc_dec, 1'b0);
    exec({5'h0B, 5'h02, 2'h0, 4'hC, 4'hE});
    chk(a_src, operand_decode_pkg::A_MEM_LOW);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h3, 32'h0);
    exec({10'h160, 2'h0, 1'b1, 7'h00});
    chk({addr_latch_load, addr_latch}, 9'h15A);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h5A);
    // Address strobe first enables the peripheral
    for (int d = 2; d >= 0; d--)
    begin
      exec({10'h160, 2'h0, 1'b0, 7'h10 << d});
      @(posedge pclk);
      #1;
      chk({address_strobe_n, output_strobe_n, control_strobe_n} ^ (3'b001 << d), 3'h7);
      repeat (STROBE_CYC) @(posedge pclk);
      #1;
      chk({address_strobe_n, output_strobe_n, control_strobe_n}, 3'h7);
    end
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[3], 1'b1);
    exec({10'h160, 2'h0, 1'b1, 7'h20});
    chk(addr_latch_load, 1'b0);
    @(posedge pclk);
    #1;
    chk(output_strobe_n, 1'b1);
    final_report();
  end
endmodule : microcode_operand_field_decoder_tb

bind microcode_operand_field_decoder operand_decode_chk #(.TRAP_ADDR(TRAP_ADDR), .STROBE_CYC(STROBE_CYC),
  .TRAP_HOLD(TRAP_HOLD)) operand_decode_chk_inst (.pclk, .presetn, .instr_word, .instr_valid, .trap_force,
  .trap_addr, .a_src, .a_file_sel, .a_imm, .c_sel, .mem_op, .pc_inc, .pc_dec, .output_strobe_n);
`default_nettype wire

//--- tb/operand_decode_chk.sv
// Checker bound to the operand field decoder top.
// Assumes clk_en held high and decoding left enabled.
`timescale 1ns/1ps
`default_nettype none
module operand_decode_chk #(
  parameter logic [11:0] TRAP_ADDR  = 12'h000,
  parameter int          STROBE_CYC = 4,
  parameter int          TRAP_HOLD  = 2
)(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [19:0]                 instr_word,
  input  wire logic                        instr_valid,
  input  wire logic                        trap_force,
  input  wire logic [11:0]                 trap_addr,
  input  var  operand_decode_pkg::a_src_e  a_src,
  input  wire logic [2:0]                  a_file_sel,
  input  wire logic [3:0]                  a_imm,
  input  var  operand_decode_pkg::bc_sel_e c_sel,
  input  var  operand_decode_pkg::mem_op_e mem_op,
  input  wire logic                        pc_inc,
  input  wire logic                        pc_dec,
  input  wire logic                        output_strobe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic       take = instr_valid && !trap_force;
  wire logic       regf = take && !instr_word[19] && instr_word[19:15] != 5'h0B;
  wire logic       regn = regf && !instr_word[18];
  wire logic [3:0] af   = instr_word[7:4];
  logic [15:0] low_cnt;
  logic [1:0]  since_rst;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_cnt   <= '0;
      since_rst <= '0;
    end
    else
    begin
      low_cnt   <= output_strobe_n ? 16'h0 : low_cnt + 16'h1;
      since_rst <= (since_rst == 2'h3) ? since_rst : since_rst + 2'h1;
    end
  file_src_a: assert property (regn && !af[3] |=> a_src == operand_decode_pkg::A_FILE
    && a_file_sel == $past(instr_word[6:4])) else $error("file source wrong");
  inc_step_a: assert property (regn && af inside {4'hA, 4'hE, 4'hF} |=> !pc_inc ##1 pc_inc)
    else $error("increment step wrong");
  dec_step_a: assert property (regn && af inside {4'h9, 4'hB, 4'hD} |-> ##2 pc_dec && !pc_inc)
    else $error("decrement step wrong");
  imm_src_a: assert property (regf && instr_word[18] |=> a_src == operand_decode_pkg::A_IMM
    && a_imm == $past(instr_word[7:4])) else $error("immediate operand wrong");
  mem_op_a: assert property (take && !instr_word[19] |=> mem_op == $past(instr_word[9:8]))
    else $error("memory operation wrong");
  c_discard_a: assert property (regf && instr_word[3:0] inside {4'hD, 4'hE, 4'hF}
    |=> c_sel == operand_decode_pkg::BC_NONE) else $error("destination not discarded");
  strobe_len_a: assert property ($rose(output_strobe_n) |-> low_cnt == STROBE_CYC)
    else $error("strobe width wrong");
  trap_hold_a: assert property (since_rst < TRAP_HOLD |-> trap_force && trap_addr == TRAP_ADDR)
    else $error("trap not forced");
  out_fire_a: assert property (take && instr_word[19:10] == 10'h160 && instr_word[7:0] == 8'h20
    && output_strobe_n |-> ##2 !output_strobe_n) else $error("output strobe missing");
  cover property (take && instr_word[19:15] == 5'h0B);
  cover property ($rose(output_strobe_n));
  cover property (pc_dec);
endmodule : operand_decode_chk
`default_nettype wire
